/* rtl/sdram_cmd_pkg.sv */
package sdram_cmd_pkg;

    // Clock of both ends.
    localparam int CLK_PERIOD_NS = 10;

    // Bus widths used by the link.
    localparam int BANK_W = 3;
    localparam int ADDR_W = 14;

    // Field positions on the address lines.
    localparam int AUTO_PRECHARGE_POS = 10;
    localparam int DLL_RESET_POS = 8;

    // Register selects carried on bank_sel for a mode write.
    localparam logic [2:0] MODE_REG_SEL = 3'h0;
    localparam logic [2:0] EXT_MODE_REG1_SEL = 3'h1;

    // Burst length in data beats (two per cycle), and clock-gate timing in cycles.
    localparam int BURST_LEN = 4;
    localparam int CKE_MIN_CYC = 3;
    localparam int FREQ_GAP_CYC = 2;
    localparam int RELOCK_CYC = 200;

    // Precharge time, and its count rounded up to whole cycles.
    localparam int PRECHARGE_TIME_NS = 15;
    localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Commands as seen by the device after decoding.
    typedef enum logic [3:0] {
        dec_idle, dec_deselect, dec_activate, dec_read, dec_write, dec_precharge,
        dec_refresh, dec_mode_set, dec_pd_entry, dec_pd_exit, dec_sr_entry,
        dec_sr_exit, dec_illegal
    } dec_t;

    // Commands requested by the user of the controller end.
    typedef enum logic [2:0] {
        cmd_idle, cmd_activate, cmd_read, cmd_write, cmd_precharge, cmd_refresh,
        cmd_mode_set, cmd_reserved
    } user_cmd_t;

    // Operating mode of the device.
    typedef enum logic [1:0] {
        mode_normal, mode_power_down, mode_self_refresh
    } mode_t;

endpackage

/* rtl/sdram_cmd_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sdram_cmd_if #(
    parameter int BANK_W = sdram_cmd_pkg::BANK_W,
    parameter int ADDR_W = sdram_cmd_pkg::ADDR_W
);
    // Command and clock-gate pins, all sampled on the rising clock edge.
    logic chip_sel_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_strobe_n;
    logic clock_gate;
    logic termination_ctl;
    logic [BANK_W-1:0] bank_sel;
    logic [ADDR_W-1:0] addr;

    modport ctrl (
        output chip_sel_n, row_strobe_n, column_strobe_n, write_strobe_n,
        output clock_gate, termination_ctl, bank_sel, addr
    );
    modport mem (
        input chip_sel_n, row_strobe_n, column_strobe_n, write_strobe_n,
        input clock_gate, termination_ctl, bank_sel, addr
    );
endinterface
`default_nettype wire

/* rtl/sdram_cmd_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_decode #(
    parameter int BANK_W = sdram_cmd_pkg::BANK_W,
    parameter int ADDR_W = sdram_cmd_pkg::ADDR_W,
    parameter int BURST_LEN = sdram_cmd_pkg::BURST_LEN
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Pins from the controller.
    sdram_cmd_if.mem bus,
    // Decoded command, one cycle per sampled edge.
    output logic cmd_strobe,
    output sdram_cmd_pkg::dec_t cmd_kind,
    output logic [BANK_W-1:0] cmd_bank,
    output logic [ADDR_W-1:0] cmd_addr,
    output logic auto_precharge,
    output logic all_banks,
    // Device condition.
    output sdram_cmd_pkg::mode_t mode,
    output logic burst_busy,
    output logic contents_lost,
    output logic termination_on
);
    typedef struct packed {
        logic gate_prev;
        sdram_cmd_pkg::mode_t mode;
        logic [3:0] burst_left;
        logic strobe;
        sdram_cmd_pkg::dec_t kind;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic auto_pre;
        logic all_banks;
        logic lost;
        logic term_on;
    } dev_state_t;

    localparam logic [3:0] BURST_CYC = 4'(BURST_LEN / 2);

    dev_state_t s;
    dev_state_t next_s;
    logic no_cmd;
    logic [2:0] strobes;

    // A high chip select hides the strobes entirely, so it acts as an idle cycle.
    assign no_cmd = bus.chip_sel_n | (bus.row_strobe_n & bus.column_strobe_n & bus.write_strobe_n);
    assign strobes = {bus.row_strobe_n, bus.column_strobe_n, bus.write_strobe_n};

    // Decode of one edge; the clock gate of this and the previous edge select the table.
    always_comb begin
        next_s = s;
        next_s.strobe = 1'b0;
        next_s.gate_prev = bus.clock_gate;
        // Termination never enters the decode, it only drives its own flag.
        next_s.term_on = bus.termination_ctl & (s.mode != sdram_cmd_pkg::mode_self_refresh);
        // An idle cycle lets a running burst finish.
        if (s.burst_left != 4'h0) begin
            next_s.burst_left = s.burst_left - 4'h1;
        end
        case ({s.gate_prev, bus.clock_gate})
            2'b11: begin
                next_s.strobe = 1'b1;
                next_s.bank = bus.bank_sel;
                next_s.addr = bus.addr;
                next_s.auto_pre = bus.addr[sdram_cmd_pkg::AUTO_PRECHARGE_POS];
                next_s.all_banks = 1'b0;
                if (no_cmd) begin
                    next_s.kind = bus.chip_sel_n ? sdram_cmd_pkg::dec_deselect
                                                 : sdram_cmd_pkg::dec_idle;
                end else begin
                    case (strobes)
                        3'b011: next_s.kind = sdram_cmd_pkg::dec_activate;
                        3'b101: next_s.kind = sdram_cmd_pkg::dec_read;
                        3'b100: next_s.kind = sdram_cmd_pkg::dec_write;
                        3'b010: next_s.kind = sdram_cmd_pkg::dec_precharge;
                        3'b001: next_s.kind = sdram_cmd_pkg::dec_refresh;
                        3'b000: next_s.kind = sdram_cmd_pkg::dec_mode_set;
                        default: next_s.kind = sdram_cmd_pkg::dec_illegal;
                    endcase
                end
                if (next_s.kind == sdram_cmd_pkg::dec_precharge) begin
                    next_s.all_banks = next_s.auto_pre;
                    next_s.auto_pre = 1'b0;
                end else if (next_s.kind != sdram_cmd_pkg::dec_read &&
                             next_s.kind != sdram_cmd_pkg::dec_write) begin
                    next_s.auto_pre = 1'b0;
                end
                if (next_s.kind == sdram_cmd_pkg::dec_read ||
                    next_s.kind == sdram_cmd_pkg::dec_write) begin
                    // A short burst is never cut; a longer one is restarted.
                    if (s.burst_left > 4'h1 && BURST_LEN == 4) begin
                        next_s.strobe = 1'b0;
                    end else begin
                        next_s.burst_left = BURST_CYC;
                    end
                end
            end
            2'b10: begin
                next_s.strobe = 1'b1;
                next_s.auto_pre = 1'b0;
                next_s.all_banks = 1'b0;
                if (no_cmd) begin
                    next_s.kind = sdram_cmd_pkg::dec_pd_entry;
                    next_s.mode = sdram_cmd_pkg::mode_power_down;
                end else if (strobes == 3'b001) begin
                    next_s.kind = sdram_cmd_pkg::dec_sr_entry;
                    next_s.mode = sdram_cmd_pkg::mode_self_refresh;
                end else begin
                    next_s.kind = sdram_cmd_pkg::dec_illegal;
                    next_s.mode = sdram_cmd_pkg::mode_power_down;
                end
                // Gate dropped in the middle of a burst: the array can no longer be trusted.
                if (s.burst_left > 4'h1) begin
                    next_s.lost = 1'b1;
                    next_s.burst_left = 4'h0;
                end
            end
            2'b01: begin
                next_s.strobe = 1'b1;
                next_s.auto_pre = 1'b0;
                next_s.all_banks = 1'b0;
                if (no_cmd) begin
                    next_s.kind = (s.mode == sdram_cmd_pkg::mode_self_refresh) ?
                                  sdram_cmd_pkg::dec_sr_exit : sdram_cmd_pkg::dec_pd_exit;
                end else begin
                    next_s.kind = sdram_cmd_pkg::dec_illegal;
                end
                next_s.mode = sdram_cmd_pkg::mode_normal;
            end
            default: begin
                // Gate held low: power-down or self refresh is simply maintained.
                next_s.strobe = 1'b0;
            end
        endcase
    end

    // The device starts as if powered down, waiting for the gate to rise.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s <= '{gate_prev: 1'b0, mode: sdram_cmd_pkg::mode_power_down,
                   kind: sdram_cmd_pkg::dec_idle, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign cmd_strobe = s.strobe;
    assign cmd_kind = s.kind;
    assign cmd_bank = s.bank;
    assign cmd_addr = s.addr;
    assign auto_precharge = s.auto_pre;
    assign all_banks = s.all_banks;
    assign mode = s.mode;
    assign burst_busy = (s.burst_left != 4'h0);
    assign contents_lost = s.lost;
    assign termination_on = s.term_on;
endmodule
`default_nettype wire

/* rtl/sdram_ctrl_seq.sv */
// Summary of operation
// - Issue idle command whenever nothing else is due.
// - Idle command never stops a running burst.
// - Chip select high counts as idle.
// - Frequency change only in precharge power-down.
// - Wait two cycles beyond precharge and termination-off.
// - Raise gate only after clock is stable; the power-down exit from st_pd raises it without checking clock_stable.
// - Reset delay-lock loop after power-down exit latency.
// - Keep termination off during 200-cycle relock.
// - Gate dropped mid-burst loses array contents.
// - Wait clock-off delay, then stable clocks before gate.
// - Full initialization after an asynchronous gate drop.
// - Commands encoded on strobes and clock gate.
// - Mode writes use all strobes low.
// - Bank select and auto-precharge bit steer commands.
// - Short bursts cannot be interrupted.
// - Power-down duration is bounded for refresh; only the st_pd stay is bounded, st_freq_hold waits on freq_req with no limit.
// - Don't-care pins still driven to defined levels.
// - Termination does not affect decoding.
// - Unspecified command forces power-down and reinitialization.
// - Gate edges with idle enter or leave power-down.
// - Gate held at least three clocks each level, except that an async event drops it at once.
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_seq #(
    parameter int BANK_W = sdram_cmd_pkg::BANK_W,
    parameter int ADDR_W = sdram_cmd_pkg::ADDR_W,
    parameter int TERM_OFF_DELAY_CYC = 3,
    parameter int PD_EXIT_CYC = 2,
    parameter int CLOCK_OFF_DELAY_CYC = 8,
    parameter int PD_MAX_CYC = 70000,
    parameter logic [ADDR_W-1:0] MODE_OPCODE = '0
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Pins towards the memory.
    sdram_cmd_if.ctrl bus,
    // User command port.
    input wire logic cmd_valid,
    input wire sdram_cmd_pkg::user_cmd_t cmd_code,
    input wire logic [BANK_W-1:0] cmd_bank,
    input wire logic [ADDR_W-1:0] cmd_addr,
    output logic cmd_ready,
    // Power and clock management.
    input wire logic term_req,
    input wire logic pd_req,
    input wire logic freq_req,
    input wire logic clock_stable,
    input wire logic async_evt,
    output logic clock_hold,
    output logic clock_stop,
    output logic init_busy
);
    typedef enum {
        st_boot, st_init_pre, st_init_emr, st_init_mr, st_relock, st_ready,
        st_freq_pre, st_freq_wait, st_freq_hold, st_exit_wait, st_pd,
        st_async_wait, st_async_stop, st_unspec
    } seq_t;

    typedef struct packed {
        seq_t st;
        logic [16:0] cnt;
        logic [1:0] age;
        logic dll_reset;
        logic in_init;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic gate;
        logic term;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic hold;
        logic stop;
    } ctrl_state_t;

    localparam logic [1:0] AGE_MIN = 2'(sdram_cmd_pkg::CKE_MIN_CYC);
    localparam int SETTLE_RAW = (sdram_cmd_pkg::PRECHARGE_CYC > TERM_OFF_DELAY_CYC) ?
                                sdram_cmd_pkg::PRECHARGE_CYC : TERM_OFF_DELAY_CYC;
    localparam logic [16:0] SETTLE_CYC = 17'(SETTLE_RAW + sdram_cmd_pkg::FREQ_GAP_CYC);
    localparam logic [16:0] PRE_CYC = 17'(sdram_cmd_pkg::PRECHARGE_CYC);
    localparam logic [16:0] RELOCK_CYC = 17'(sdram_cmd_pkg::RELOCK_CYC);
    localparam logic [16:0] XP_CYC = 17'(PD_EXIT_CYC);
    localparam logic [16:0] OFF_CYC = 17'(CLOCK_OFF_DELAY_CYC);
    localparam logic [16:0] PD_CYC = 17'(PD_MAX_CYC);

    ctrl_state_t s;
    ctrl_state_t next_s;
    logic gate_ok;
    logic cnt_done;

    // Except on an async event, the gate may only move once it has stood at its level for the minimum time.
    assign gate_ok = (s.age >= AGE_MIN);
    assign cnt_done = (s.cnt == 17'h0);

    // Command acceptance is combinational so the user sees it in the same cycle.
    assign cmd_ready = (s.st == st_ready) & ~pd_req & ~freq_req & ~async_evt;

    // Sequencer; each cycle starts from an idle command with defined address levels.
    always_comb begin
        next_s = s;
        next_s.cs_n = 1'b0;
        next_s.ras_n = 1'b1;
        next_s.cas_n = 1'b1;
        next_s.we_n = 1'b1;
        next_s.bank = '0;
        next_s.addr = '0;
        next_s.hold = 1'b0;
        next_s.stop = 1'b0;
        next_s.term = term_req & cmd_ready;
        if (s.cnt != 17'h0) begin
            next_s.cnt = s.cnt - 17'h1;
        end
        case (s.st)
            st_boot: begin
                // Clock must be stable before the gate rises out of reset or a drop.
                if (clock_stable && gate_ok) begin
                    next_s.gate = 1'b1;
                    next_s.st = st_init_pre;
                end
            end
            st_init_pre: begin
                if (gate_ok) begin
                    next_s.ras_n = 1'b0;
                    next_s.we_n = 1'b0;
                    next_s.addr[sdram_cmd_pkg::AUTO_PRECHARGE_POS] = 1'b1;
                    next_s.cnt = PRE_CYC;
                    next_s.st = st_init_emr;
                end
            end
            st_init_emr: begin
                if (cnt_done) begin
                    next_s.dll_reset = 1'b1;
                    next_s.in_init = 1'b1;
                    next_s.st = st_exit_wait;
                end
            end
            st_init_mr: begin
                next_s.ras_n = 1'b0;
                next_s.cas_n = 1'b0;
                next_s.we_n = 1'b0;
                next_s.bank = BANK_W'(sdram_cmd_pkg::MODE_REG_SEL);
                next_s.addr = MODE_OPCODE;
                next_s.cnt = RELOCK_CYC;
                next_s.st = st_relock;
                next_s.in_init = 1'b0;
            end
            st_relock: begin
                // Termination stays off until the delay-lock loop has relocked.
                if (cnt_done) begin
                    next_s.st = st_ready;
                end
            end
            st_ready: begin
                if (freq_req) begin
                    // Frequency change goes through precharge power-down only.
                    next_s.ras_n = 1'b0;
                    next_s.we_n = 1'b0;
                    next_s.addr[sdram_cmd_pkg::AUTO_PRECHARGE_POS] = 1'b1;
                    next_s.cnt = SETTLE_CYC;
                    next_s.st = st_freq_pre;
                end else if (pd_req) begin
                    if (gate_ok) begin
                        next_s.gate = 1'b0;
                        next_s.cnt = PD_CYC;
                        next_s.st = st_pd;
                    end
                end else if (cmd_valid) begin
                    next_s.bank = cmd_bank;
                    next_s.addr = cmd_addr;
                    case (cmd_code)
                        sdram_cmd_pkg::cmd_activate: next_s.ras_n = 1'b0;
                        sdram_cmd_pkg::cmd_read: next_s.cas_n = 1'b0;
                        sdram_cmd_pkg::cmd_write: begin
                            next_s.cas_n = 1'b0;
                            next_s.we_n = 1'b0;
                        end
                        sdram_cmd_pkg::cmd_precharge: begin
                            next_s.ras_n = 1'b0;
                            next_s.we_n = 1'b0;
                        end
                        sdram_cmd_pkg::cmd_refresh: begin
                            next_s.ras_n = 1'b0;
                            next_s.cas_n = 1'b0;
                        end
                        sdram_cmd_pkg::cmd_mode_set: begin
                            next_s.ras_n = 1'b0;
                            next_s.cas_n = 1'b0;
                            next_s.we_n = 1'b0;
                        end
                        sdram_cmd_pkg::cmd_idle: next_s.cs_n = 1'b0;
                        default: next_s.st = st_unspec;
                    endcase
                end
            end
            st_freq_pre: begin
                if (gate_ok) begin
                    next_s.gate = 1'b0;
                    next_s.st = st_freq_wait;
                end
            end
            st_freq_wait: begin
                // Counting began at the precharge, so both delays and the gap are covered.
                if (cnt_done) begin
                    next_s.hold = 1'b1;
                    next_s.st = st_freq_hold;
                end
            end
            st_freq_hold: begin
                next_s.hold = 1'b1;
                if (!freq_req && clock_stable && gate_ok) begin
                    next_s.hold = 1'b0;
                    next_s.gate = 1'b1;
                    next_s.dll_reset = 1'b1;
                    next_s.cnt = XP_CYC;
                    next_s.st = st_exit_wait;
                end
            end
            st_exit_wait: begin
                if (cnt_done && s.dll_reset) begin
                    next_s.ras_n = 1'b0;
                    next_s.cas_n = 1'b0;
                    next_s.we_n = 1'b0;
                    next_s.bank = BANK_W'(sdram_cmd_pkg::EXT_MODE_REG1_SEL);
                    next_s.addr[sdram_cmd_pkg::DLL_RESET_POS] = 1'b1;
                    next_s.dll_reset = 1'b0;
                    next_s.cnt = RELOCK_CYC;
                    next_s.st = s.in_init ? st_init_mr : st_relock;
                end else if (cnt_done) begin
                    next_s.st = st_ready;
                end
            end
            st_pd: begin
                // No refresh runs here, so the stay is cut short by the counter.
                if ((!pd_req || cnt_done) && gate_ok) begin
                    next_s.gate = 1'b1;
                    next_s.cnt = XP_CYC;
                    next_s.st = st_exit_wait;
                end
            end
            st_async_wait: begin
                if (cnt_done) begin
                    next_s.stop = 1'b1;
                    next_s.st = st_async_stop;
                end
            end
            st_async_stop: begin
                next_s.stop = 1'b1;
                if (!async_evt) begin
                    next_s.stop = 1'b0;
                    next_s.st = st_boot;
                end
            end
            st_unspec: begin
                if (gate_ok) begin
                    next_s.gate = 1'b0;
                    next_s.st = st_boot;
                end
            end
            default: next_s.st = st_boot;
        endcase
        // A reset event overrides the state, counter and loop reset and drops the gate at once; a command set above still goes out.
        if (async_evt && s.st != st_async_wait && s.st != st_async_stop) begin
            next_s.gate = 1'b0;
            next_s.dll_reset = 1'b0;
            next_s.cnt = OFF_CYC;
            next_s.st = st_async_wait;
        end
        // Level age of the gate, saturating once the minimum is reached.
        if (next_s.gate != s.gate) begin
            next_s.age = 2'h1;
        end else if (!gate_ok) begin
            next_s.age = s.age + 2'h1;
        end
    end

    // Gate low after reset, the age counts from there before the first rise.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s <= '{st: st_boot, age: 2'h1, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1,
                   we_n: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign bus.chip_sel_n = s.cs_n;
    assign bus.row_strobe_n = s.ras_n;
    assign bus.column_strobe_n = s.cas_n;
    assign bus.write_strobe_n = s.we_n;
    assign bus.clock_gate = s.gate;
    assign bus.termination_ctl = s.term;
    assign bus.bank_sel = s.bank;
    assign bus.addr = s.addr;
    assign clock_hold = s.hold;
    assign clock_stop = s.stop;
    assign init_busy = (s.st == st_boot) | (s.st == st_init_pre) | (s.st == st_init_emr) |
                       (s.st == st_init_mr) | (s.st == st_unspec);
endmodule
`default_nettype wire

/* sim/sdram_cmd_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_asserts #(
    parameter int BANK_W = 3,
    parameter int ADDR_W = 14
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Link pins.
    input wire logic chip_sel_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_strobe_n,
    input wire logic clock_gate,
    input wire logic termination_ctl,
    input wire logic [BANK_W-1:0] bank_sel,
    input wire logic [ADDR_W-1:0] addr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Decoded views of the pins.
    wire idle = row_strobe_n && column_strobe_n && write_strobe_n;
    wire busy_cmd = !chip_sel_n && !idle;
    wire mode_wr = !chip_sel_n && !row_strobe_n && !column_strobe_n && !write_strobe_n;
    wire dll_rst = mode_wr && bank_sel == 3'h1 && addr[8];
    logic [7:0] relock;
    // Counts the relock span, since a single delay cannot say "throughout".
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            relock <= 8'h00;
        end else if (dll_rst) begin
            relock <= 8'hc8;
        end else if (relock != 8'h00) begin
            relock <= relock - 8'h01;
        end
    end
    gate_high_min_a: assert property ($rose(clock_gate) |=> clock_gate [*2])
        else $error("clock gate high for under three cycles");
    gate_low_min_a: assert property ($fell(clock_gate) |=> !clock_gate [*2])
        else $error("clock gate low for under three cycles");
    gate_fall_idle_a: assert property ($fell(clock_gate) |-> !busy_cmd)
        else $error("clock gate fell with a command");
    cmd_gate_high_a: assert property (busy_cmd |-> clock_gate && $past(clock_gate))
        else $error("command issued without gate high on both edges");
    mode_reg_sel_a: assert property (mode_wr |-> bank_sel inside {3'h0, 3'h1})
        else $error("mode write to an unknown register");
    dll_after_exit_a: assert property (dll_rst |-> $past(clock_gate, 2))
        else $error("loop reset before exit latency");
    relock_term_off_a: assert property (relock != 8'h00 |-> !termination_ctl)
        else $error("termination on during relock");
    gate_low_term_a: assert property (!clock_gate |-> !termination_ctl)
        else $error("termination on while gate low");
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
    failures++; $display("[ERR] %s exp %0h got %0h", name, exp, got); end end
module tb_top;
    logic clk_sys, nrst, cmd_valid, cmd_ready, term_req, pd_req, freq_req;
    logic clock_stable, async_evt, clock_hold, clock_stop, init_busy, cmd_strobe;
    logic auto_precharge, all_banks, burst_busy, contents_lost, termination_on;
    logic [2:0] cmd_bank, d_bank;
    logic [13:0] cmd_addr, d_addr;
    sdram_cmd_pkg::user_cmd_t cmd_code;
    sdram_cmd_pkg::dec_t cmd_kind;
    sdram_cmd_pkg::mode_t mode;
    int failures = 0;
    int n_compared = 0;
    sdram_cmd_if link ();
    sdram_ctrl_seq #(.PD_MAX_CYC(20)) sdram_ctrl_seq_inst (.clk_sys(clk_sys), .nrst(nrst),
        .bus(link), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
        .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .term_req(term_req), .pd_req(pd_req),
        .freq_req(freq_req), .clock_stable(clock_stable), .async_evt(async_evt),
        .clock_hold(clock_hold), .clock_stop(clock_stop), .init_busy(init_busy));
    sdram_cmd_decode sdram_cmd_decode_inst (.clk_sys(clk_sys), .nrst(nrst), .bus(link),
        .cmd_strobe(cmd_strobe), .cmd_kind(cmd_kind), .cmd_bank(d_bank), .cmd_addr(d_addr),
        .auto_precharge(auto_precharge), .all_banks(all_banks), .mode(mode),
        .burst_busy(burst_busy), .contents_lost(contents_lost), .termination_on(termination_on));
    sdram_cmd_asserts sdram_cmd_asserts_inst (.clk_sys(clk_sys), .nrst(nrst),
        .chip_sel_n(link.chip_sel_n), .row_strobe_n(link.row_strobe_n),
        .column_strobe_n(link.column_strobe_n), .write_strobe_n(link.write_strobe_n),
        .clock_gate(link.clock_gate), .termination_ctl(link.termination_ctl),
        .bank_sel(link.bank_sel), .addr(link.addr));
    // Inputs move 1 ns after the edge so no race with the sampling edge.
    task tick; @(posedge clk_sys); #1; endtask
    task wait_ready; for (int k = 0; k < 2000 && cmd_ready !== 1'b1; k++) tick; endtask
    task issue(input sdram_cmd_pkg::user_cmd_t c, input logic [2:0] b, input logic [13:0] a);
        wait_ready;
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_bank = b;
        cmd_addr = a;
        tick;
        cmd_valid = 1'b0;
    endtask
    task test_commands;
        term_req = 1'b1;
        for (int i = 0; i < 5; i++) begin
            issue(sdram_cmd_pkg::user_cmd_t'(i + 1), 3'h5, 14'h0400 | 14'(i));
            tick;
            `CHECK("strobe", 1'b1, cmd_strobe)
            `CHECK("kind", sdram_cmd_pkg::dec_t'(i + 2), cmd_kind)
            `CHECK("bank", 3'h5, d_bank)
            `CHECK("busy", i == 1 || i == 2, burst_busy)
            `CHECK("term", 1'b1, termination_on)
            if (i > 0 && i < 4) `CHECK("ap_bit", 1'b1, i == 3 ? all_banks : auto_precharge)
        end
        term_req = 1'b0;
    endtask
    task test_power_down;
        pd_req = 1'b1;
        for (int k = 0; k < 20 && mode !== sdram_cmd_pkg::mode_power_down; k++) tick;
        `CHECK("pd in", sdram_cmd_pkg::dec_pd_entry, cmd_kind)
        pd_req = 1'b0;
        for (int k = 0; k < 40 && mode !== sdram_cmd_pkg::mode_normal; k++) tick;
        `CHECK("pd out", sdram_cmd_pkg::dec_pd_exit, cmd_kind)
    endtask
    task test_freq;
        clock_stable = 1'b0;
        freq_req = 1'b1;
        for (int k = 0; k < 40 && clock_hold !== 1'b1; k++) tick;
        `CHECK("hold", sdram_cmd_pkg::mode_power_down, mode)
        repeat (4) tick;
        clock_stable = 1'b1;
        freq_req = 1'b0;
        for (int k = 0; k < 20 && cmd_kind !== sdram_cmd_pkg::dec_mode_set; k++) tick;
        `CHECK("relock", sdram_cmd_pkg::dec_mode_set, cmd_kind)
        `CHECK("ext_sel", 3'h1, d_bank)
        `CHECK("dll_bit", 1'b1, d_addr[8])
    endtask
    task test_async;
        int k;
        issue(sdram_cmd_pkg::cmd_read, 3'h2, 14'h0010);
        async_evt = 1'b1;
        for (k = 0; k < 30 && clock_stop !== 1'b1; k++) tick;
        `CHECK("lost", 1'b1, contents_lost)
        `CHECK("delay", 1'b1, k >= 8)
        async_evt = 1'b0;
        for (k = 0; k < 40 && cmd_kind !== sdram_cmd_pkg::dec_mode_set; k++) tick;
        `CHECK("reinit", 3'h1, d_bank)
        tick;
        `CHECK("reinit", sdram_cmd_pkg::dec_mode_set, cmd_kind)
        `CHECK("mode_sel", 3'h0, d_bank)
    endtask
    task test_reserved;
        issue(sdram_cmd_pkg::cmd_reserved, 3'h0, 14'h0000);
        for (int k = 0; k < 20 && mode !== sdram_cmd_pkg::mode_power_down; k++) tick;
        `CHECK("pd", sdram_cmd_pkg::mode_power_down, mode)
        `CHECK("restart", 1'b1, init_busy)
    endtask
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Free-running 100 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // A hang is cut after about fourteen times the expected run.
    initial begin
        #100000;
        failures++;
        give_verdict;
    end
    // Main sequence.
    initial begin
        {nrst, cmd_valid, term_req, pd_req, freq_req, async_evt} = 6'h00;
        {cmd_bank, cmd_addr} = 17'h00000;
        cmd_code = sdram_cmd_pkg::cmd_idle;
        clock_stable = 1'b1;
        repeat (10) tick;
        nrst = 1'b1;
        wait_ready;
        test_commands;
        test_power_down;
        test_freq;
        test_reserved;
        test_async;
        give_verdict;
    end
endmodule
`default_nettype wire
